//--- hdl/fnc_pkg.sv
// Purpose : Shared constants and types for the flash and NV config controller
// Assumes : Single 250 MHz clock, synchronous active-high reset
// Notes   : Option bit and protection values survive system reset
package fnc_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int PAGE_COUNT      = 1024;            // Pages in the array
    localparam int PAGE_BYTES      = 256;             // Bytes per page
    localparam int PAGE_WORDS      = PAGE_BYTES / 4;  // 32-bit words per page
    localparam int PAGE_AW         = 10;              // Page number width
    localparam int GPNV_COUNT      = 3;               // Non-volatile option bits
    // ----------------------------------------------------------------
    // Reset values and memory map
    // ----------------------------------------------------------------
    localparam logic [7:0]  CALIB_FACTORY   = 8'h80;  // Arbitrary factory trim
    localparam logic [2:0]  GPNV_RESET      = 3'h0;   // Option bits at first power
    localparam logic [31:0] LOW_WIN_LAST    = 32'h000f_ffff; // Low window top
    // ----------------------------------------------------------------
    // Commands and sources
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE, CMD_PAGE_PROG, CMD_PAGE_ERASE, CMD_FULL_ERASE, CMD_LOCK,
        CMD_UNLOCK, CMD_SET_PROT, CMD_SET_GPNV, CMD_CLR_GPNV, CMD_READ
    } fnc_cmd_t;
    typedef enum logic [1:0] { MAP_FLASH, MAP_ROM, MAP_SRAM } fnc_map_t;
    typedef struct packed {
        fnc_cmd_t             cmd;    // Command code
        logic [PAGE_AW-1:0]   page;   // Page or option bit number
    } fnc_req_t;
    typedef struct packed {
        logic busy;      // Command running
        logic done;      // Last command ended
        logic err_busy;  // Command refused while busy
        logic err_prot;  // Refused by page lock
    } fnc_stat_t;
endpackage : fnc_pkg

//--- hdl/fnc_ctrl.sv
// Purpose : Flash controller, option bits, protection, remap, prog-port entry
// Assumes : Array modelled as a register memory; NV state held across reset
// Notes   : Behaviour
// Behaviour
// (RULE1) Protection set only by protect command
// (RULE2) Protection clears after wipe pin plus erase
// (RULE3) Protected: programming port access refused
// (RULE4) Wipe pin held over 220 ms externally
// (RULE5) Option bits set/clear commands, non-volatile
// (RULE6) Bit 0 enables brownout; wipe clears
// (RULE7) Bit 1 enables brownout reset; wipe clears
// (RULE8) Eight calibration bits fixed, wipe-proof
// (RULE9) Bit 2 set: boot from flash
// (RULE10) Bit 2 clear: boot ROM at zero
// (RULE11) Remap puts SRAM in low window
// (RULE12) Prog port needs test pin, lines high
// (RULE13) Prog port command set supported
// (RULE14) Array standby when idle
// (RULE15) 256-byte page buffer, 32-bit writes
// (RULE16) Software commands with end/error status
// (RULE17) Interrupt on done or error, enabled
// (RULE18) Software sets wait states and timing
// (RULE19) Two-word prefetch buffer for fetches
// (RULE20) 1024 pages of 256 bytes
// (RULE21) Command while busy refused, flagged
// (RULE22) Busy until array operation finished
`timescale 1ns/10ps
`default_nettype none
module fnc_ctrl
    import fnc_pkg::*;
(
    input  wire logic         I_CLK,            // System clock
    input  wire logic         I_RESET,          // Sync reset, active high
    input  wire fnc_req_t     I_SW_REQ,         // Software command
    input  wire logic         I_SW_REQ_VALID,   // Software command strobe
    input  wire logic [3:0]   I_WAIT_STATES,    // Read wait states
    input  wire logic [7:0]   I_OP_CYCLES,      // Cycles per array step, minus one
    input  wire logic [1:0]   I_IRQ_ENABLE,     // [0] done, [1] error
    input  wire logic         I_REMAP,          // Remap command pulse
    input  wire logic         I_BUF_WE,         // Page buffer write strobe
    input  wire logic [5:0]   I_BUF_ADDR,       // Page buffer word index
    input  wire logic [31:0]  I_BUF_WDATA,      // Page buffer write data
    input  wire logic         I_RD_REQ,         // Fetch request
    input  wire logic [17:0]  I_RD_ADDR,        // Fetch byte address
    input  wire logic         I_WIPE_PIN,       // External wipe pin
    input  wire logic         I_TEST_MODE_PIN,  // Test-mode strap
    input  wire logic         I_PORT_A_LINE_ZERO, // Strap line zero
    input  wire logic         I_PORT_A_LINE_ONE,  // Strap line one
    input  wire fnc_req_t     I_PP_REQ,         // Programming port command
    input  wire logic         I_PP_REQ_VALID,   // Programming port strobe
    output fnc_stat_t         O_STATUS,         // Command status
    output logic              O_IRQ,            // Interrupt level
    output logic              O_RD_VALID,       // Fetch data valid
    output logic [31:0]       O_RD_DATA,        // Fetch data
    output logic              O_PP_ENABLE,      // Programming mode active
    output logic              O_PP_REFUSED,     // Last port command refused
    output logic              O_PROTECTED,      // Protection flag
    output logic [2:0]        O_GPNV,           // Option bits
    output logic              O_BROWNOUT_EN,    // Brownout detector enable
    output logic              O_BROWNOUT_RST_EN,// Brownout reset enable
    output logic [7:0]        O_CALIB,          // Factory calibration bits
    output fnc_map_t          O_LOW_MAP,        // What sits in low window
    output logic [31:0]       O_LOW_WIN_LAST,   // Low window top address
    output logic              O_ARRAY_STANDBY   // Array in standby
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [31:0] array_mem [PAGE_COUNT*PAGE_WORDS]; // Array contents (RULE20)
    logic [31:0] page_buf [PAGE_WORDS]; // Page write buffer
    // NV state: power-up values only, system reset leaves them; remap_reg is cleared by reset
    logic [PAGE_COUNT-1:0] lock_reg = '0; // Per-page lock
    logic        prot_reg = 1'b0; // Protection flag
    logic        wipe_seen_reg = 1'b0; // Wipe pin seen
    logic [2:0]  gpnv_reg = GPNV_RESET; // Option bits
    logic        remap_reg; // Remap done
    typedef enum { ST_IDLE, ST_RUN, ST_READ } st_t;
    st_t         st_reg; // Sequencer state
    fnc_req_t    cur_reg; // Running command
    logic [16:0] cnt_reg; // Step counter
    logic [7:0]  step_reg; // Step delay
    logic        done_reg; // End status
    logic        err_busy_reg; // Busy error
    logic        err_prot_reg; // Protection error
    logic        pp_refused_reg; // Port refusal
    logic [31:0] rd_data_reg; // Fetch data
    logic        rd_valid_reg; // Fetch valid
    logic [3:0]  wait_reg; // Wait counter
    logic [15:0] pf_tag_reg; // Prefetch word pair tag
    logic        pf_valid_reg; // Prefetch valid
    logic [31:0] pf_word [2]; // Prefetch pair
    logic [17:0] rd_addr_reg; // Pending fetch address

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire pp_enable = I_TEST_MODE_PIN & I_PORT_A_LINE_ZERO & I_PORT_A_LINE_ONE; // RULE12
    wire pp_go     = pp_enable & I_PP_REQ_VALID;
    wire pp_block  = pp_go & prot_reg; // RULE3
    wire any_req   = I_SW_REQ_VALID | (pp_go & ~prot_reg);
    fnc_req_t req;
    assign req     = I_SW_REQ_VALID ? I_SW_REQ : I_PP_REQ; // Software first
    wire busy      = (st_reg == ST_RUN); // RULE22
    wire start     = any_req & (st_reg == ST_IDLE);
    wire refuse    = any_req & busy; // RULE21
    wire [15:0] pair_tag = {1'b0, I_RD_ADDR[17:3]};
    wire pf_hit    = pf_valid_reg & (pf_tag_reg == pair_tag); // RULE19
    wire last_step = (step_reg == 8'h00);
    // Word steps per command: whole array, one page, or one
    wire full_len   = (cur_reg.cmd == CMD_FULL_ERASE);
    wire page_len   = (cur_reg.cmd == CMD_PAGE_PROG) || (cur_reg.cmd == CMD_PAGE_ERASE);
    wire finish_now = full_len ? (cnt_reg == 17'(PAGE_COUNT*PAGE_WORDS - 1))
                    : page_len ? (cnt_reg == 17'(PAGE_WORDS - 1)) : 1'b1;

    function automatic logic is_locked_cmd(input fnc_cmd_t c);
        is_locked_cmd = (c == CMD_PAGE_PROG) || (c == CMD_PAGE_ERASE);
    endfunction : is_locked_cmd

    // ----------------------------------------------------------------
    // Page buffer writes
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_BUF_WE) begin
            page_buf[I_BUF_ADDR] <= I_BUF_WDATA; // RULE15
        end
    end

    // ----------------------------------------------------------------
    // Array write path, one word per step
    // ----------------------------------------------------------------
    wire [15:0] wr_idx = {cur_reg.page, cnt_reg[5:0]};
    always_ff @(posedge I_CLK) begin
        if (busy && last_step) begin
            case (cur_reg.cmd)
                CMD_PAGE_PROG:  array_mem[wr_idx] <= page_buf[cnt_reg[5:0]]; // RULE16
                CMD_PAGE_ERASE: array_mem[wr_idx] <= 32'hffff_ffff;
                CMD_FULL_ERASE: array_mem[cnt_reg[15:0]] <= 32'hffff_ffff;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command sequencer and NV state
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_WIPE_PIN) begin
            wipe_seen_reg <= 1'b1;
            gpnv_reg[1:0] <= 2'h0;                       // RULE6 RULE7
        end
        if (I_RESET) begin
            st_reg         <= ST_IDLE;
            cur_reg        <= '0;
            cnt_reg        <= '0;
            step_reg       <= '0;
            done_reg       <= 1'b0;
            err_busy_reg   <= 1'b0;
            err_prot_reg   <= 1'b0;
            pp_refused_reg <= 1'b0;
            remap_reg      <= 1'b0;
            rd_valid_reg   <= 1'b0;
            pf_valid_reg   <= 1'b0;
            wait_reg       <= '0;
        end else begin
            rd_valid_reg <= 1'b0;
            if (I_REMAP) remap_reg <= 1'b1;               // RULE11
            if (pp_go) pp_refused_reg <= pp_block;
            if (refuse) err_busy_reg <= 1'b1;             // RULE21
            case (st_reg)
                ST_IDLE: begin
                    if (start) begin
                        done_reg     <= 1'b0;
                        err_busy_reg <= 1'b0;
                        err_prot_reg <= 1'b0;
                        if (is_locked_cmd(req.cmd) && lock_reg[req.page]) begin
                            err_prot_reg <= 1'b1;         // RULE16
                            done_reg     <= 1'b1;
                        end else begin
                            cur_reg  <= req;
                            cnt_reg  <= '0;
                            step_reg <= I_OP_CYCLES;      // RULE18
                            st_reg   <= ST_RUN;
                        end
                    end else if (I_RD_REQ && !pf_hit) begin
                        rd_addr_reg <= I_RD_ADDR;
                        wait_reg    <= I_WAIT_STATES;     // RULE18
                        st_reg      <= ST_READ;
                    end else if (I_RD_REQ) begin
                        rd_data_reg  <= pf_word[I_RD_ADDR[2]];
                        rd_valid_reg <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (wait_reg == 4'h0) begin
                        pf_word[0]   <= array_mem[{rd_addr_reg[17:3], 1'b0}];
                        pf_word[1]   <= array_mem[{rd_addr_reg[17:3], 1'b1}];
                        pf_tag_reg   <= {1'b0, rd_addr_reg[17:3]};
                        pf_valid_reg <= 1'b1;
                        rd_data_reg  <= array_mem[rd_addr_reg[17:2]];
                        rd_valid_reg <= 1'b1;
                        st_reg       <= ST_IDLE;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                ST_RUN: begin
                    if (!last_step) begin
                        step_reg <= step_reg - 8'h01;
                    end else begin
                        step_reg <= I_OP_CYCLES;
                        cnt_reg  <= cnt_reg + 17'h1;
                        pf_valid_reg <= 1'b0;
                        if (finish_now) begin
                            st_reg   <= ST_IDLE;
                            done_reg <= 1'b1;             // RULE22
                            case (cur_reg.cmd)
                                CMD_SET_PROT: prot_reg <= 1'b1;   // RULE1
                                CMD_SET_GPNV: gpnv_reg[cur_reg.page[1:0]] <= 1'b1; // RULE5
                                CMD_CLR_GPNV: gpnv_reg[cur_reg.page[1:0]] <= 1'b0; // RULE5
                                CMD_LOCK:     lock_reg[cur_reg.page] <= 1'b1;      // RULE13
                                CMD_UNLOCK:   lock_reg[cur_reg.page] <= 1'b0;      // RULE13
                                CMD_FULL_ERASE: begin
                                    if (wipe_seen_reg) prot_reg <= 1'b0; // RULE2
                                    wipe_seen_reg <= 1'b0;
                                end
                                default: ;
                            endcase
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign O_STATUS          = {busy, done_reg, err_busy_reg, err_prot_reg};
    assign O_IRQ             = (I_IRQ_ENABLE[0] & done_reg) |
                               (I_IRQ_ENABLE[1] & (err_busy_reg | err_prot_reg)); // RULE17
    assign O_RD_VALID        = rd_valid_reg;
    assign O_RD_DATA         = rd_data_reg;
    assign O_PP_ENABLE       = pp_enable; // RULE12
    assign O_PP_REFUSED      = pp_refused_reg; // RULE3
    assign O_PROTECTED       = prot_reg;
    assign O_GPNV            = gpnv_reg;
    assign O_BROWNOUT_EN     = gpnv_reg[0]; // RULE6
    assign O_BROWNOUT_RST_EN = gpnv_reg[1]; // RULE7
    assign O_CALIB           = CALIB_FACTORY; // RULE8
    assign O_LOW_MAP         = remap_reg ? MAP_SRAM : // RULE11
                               gpnv_reg[2] ? MAP_FLASH : MAP_ROM; // RULE9 RULE10
    assign O_LOW_WIN_LAST    = LOW_WIN_LAST;
    assign O_ARRAY_STANDBY   = (st_reg == ST_IDLE); // RULE14
endmodule : fnc_ctrl
`default_nettype wire

//--- bench/fnc_prog_model.sv
// Purpose : Far side model: programmer straps, wipe pin, programming port
// Assumes : Driven from tb through its tasks, changes only at rising edges
// Notes   : Wipe hold scaled by CYC_PER_MS so a run stays short
`timescale 1ns/10ps
`default_nettype none
module fnc_prog_model
    import fnc_pkg::*;
#(
    parameter int WIPE_MS    = 220,    // Minimum wipe hold time
    parameter int CYC_PER_MS = 250000  // Clock cycles per millisecond
) (
    input  wire logic i_clk,           // System clock
    output var logic  o_wipe_pin,      // Wipe pin, pulled down when idle
    output var logic  o_test_mode_pin, // Test-mode strap
    output var logic  o_line_zero,     // Strap line zero
    output var logic  o_line_one,      // Strap line one
    output fnc_req_t  o_pp_req,        // Port command
    output var logic  o_pp_req_valid   // Port strobe
);
    // -----------------------------------------------------------
    // Idle levels at time zero
    // -----------------------------------------------------------
    initial begin
        o_wipe_pin      = 1'b0;
        o_test_mode_pin = 1'b0;
        o_line_zero     = 1'b0;
        o_line_one      = 1'b0;
        o_pp_req        = '0;
        o_pp_req_valid  = 1'b0;
    end
    // Raise or drop all three straps together
    task automatic enter(input logic on);
        @(posedge i_clk);
        o_test_mode_pin <= on;
        o_line_zero     <= on;
        o_line_one      <= on;
        @(posedge i_clk);
    endtask : enter
    // One port command; released lines show the inverse of the last value
    task automatic send(input fnc_cmd_t c, input int p);
        @(posedge i_clk);
        o_pp_req       <= '{cmd: c, page: p[PAGE_AW-1:0]};
        o_pp_req_valid <= 1'b1;
        @(posedge i_clk);
        o_pp_req_valid <= 1'b0;
        o_pp_req       <= fnc_req_t'(~o_pp_req);
        repeat (2) @(posedge i_clk);
    endtask : send
    // Wipe pin held longer than the minimum time
    task automatic wipe();
        @(posedge i_clk);
        o_wipe_pin <= 1'b1;
        repeat (WIPE_MS * CYC_PER_MS + 1) @(posedge i_clk);
        o_wipe_pin <= 1'b0;
        @(posedge i_clk);
    endtask : wipe
endmodule : fnc_prog_model
`default_nettype wire

//--- bench/fnc_ctrl_monitor.sv
// Purpose : Concurrent checks on the flash controller top ports
// Assumes : Single clock, sync active-high reset
// Notes   : Bound into fnc_ctrl below
`timescale 1ns/10ps
`default_nettype none
module fnc_ctrl_monitor
    import fnc_pkg::*;
(
    input wire logic       I_CLK,              // System clock
    input wire logic       I_RESET,            // Sync reset
    input wire logic       I_SW_REQ_VALID,     // Software strobe
    input wire logic       I_REMAP,            // Remap pulse
    input wire logic       I_RD_REQ,           // Fetch request
    input wire logic       I_WIPE_PIN,         // Wipe pin
    input wire logic       I_TEST_MODE_PIN,    // Strap
    input wire logic       I_PORT_A_LINE_ZERO, // Strap
    input wire logic       I_PORT_A_LINE_ONE,  // Strap
    input wire fnc_stat_t  O_STATUS,           // Status
    input wire logic       O_RD_VALID,         // Fetch valid
    input wire logic       O_PP_ENABLE,        // Port enable
    input wire logic       O_PROTECTED,        // Protection flag
    input wire logic [2:0] O_GPNV,             // Option bits
    input wire logic       O_BROWNOUT_EN,      // Brownout enable
    input wire logic       O_BROWNOUT_RST_EN,  // Brownout reset enable
    input wire logic [7:0] O_CALIB,            // Calibration bits
    input wire fnc_map_t   O_LOW_MAP,          // Low window map
    input wire logic       O_ARRAY_STANDBY     // Standby
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    prot_set_a: assert property ($rose(O_PROTECTED) |-> $past(O_STATUS.busy))
        else $error("protection rose without a command");
    prot_clr_a: assert property ($fell(O_PROTECTED) |-> $past(O_STATUS.busy))
        else $error("protection fell without an erase");
    nv_change_a: assert property (!$stable(O_GPNV) |-> $past(O_STATUS.busy) || $past(I_WIPE_PIN))
        else $error("option bits changed without cause");
    bod_en_a: assert property (O_BROWNOUT_EN == O_GPNV[0])
        else $error("brownout enable differs from bit 0");
    bod_rst_a: assert property (O_BROWNOUT_RST_EN == O_GPNV[1])
        else $error("brownout reset differs from bit 1");
    calib_fix_a: assert property (O_CALIB == CALIB_FACTORY)
        else $error("calibration bits changed");
    boot_map_a: assert property (O_LOW_MAP != MAP_SRAM |->
        O_LOW_MAP == (O_GPNV[2] ? MAP_FLASH : MAP_ROM))
        else $error("boot mapping wrong");
    remap_sram_a: assert property (I_REMAP |-> ##[1:2] O_LOW_MAP == MAP_SRAM)
        else $error("remap did not place sram");
    pp_entry_a: assert property (O_PP_ENABLE ==
        (I_TEST_MODE_PIN && I_PORT_A_LINE_ZERO && I_PORT_A_LINE_ONE))
        else $error("port enable wrong");
    standby_a: assert property (O_STATUS.busy |-> !O_ARRAY_STANDBY)
        else $error("standby while busy");
    fetch_ans_a: assert property (I_RD_REQ && !O_STATUS.busy |-> ##[1:18] O_RD_VALID)
        else $error("fetch not answered");
    busy_ref_a: assert property (O_STATUS.busy && I_SW_REQ_VALID |=> O_STATUS.err_busy)
        else $error("command while busy not flagged");
    done_late_a: assert property ($rose(O_STATUS.done) && !O_STATUS.err_prot |->
        $past(O_STATUS.busy))
        else $error("done without a running command");
    // -----------------------------------------------------------
    // Covers
    // -----------------------------------------------------------
    prot_cv: cover property ($rose(O_PROTECTED));
    ebusy_cv: cover property ($rose(O_STATUS.err_busy));
    fetch_cv: cover property (O_RD_VALID);
    sram_cv: cover property (O_LOW_MAP == MAP_SRAM);
endmodule : fnc_ctrl_monitor
bind fnc_ctrl fnc_ctrl_monitor i_mon (.I_CLK(I_CLK), .I_RESET(I_RESET),
    .I_SW_REQ_VALID(I_SW_REQ_VALID), .I_REMAP(I_REMAP), .I_RD_REQ(I_RD_REQ),
    .I_WIPE_PIN(I_WIPE_PIN), .I_TEST_MODE_PIN(I_TEST_MODE_PIN),
    .I_PORT_A_LINE_ZERO(I_PORT_A_LINE_ZERO), .I_PORT_A_LINE_ONE(I_PORT_A_LINE_ONE),
    .O_STATUS(O_STATUS), .O_RD_VALID(O_RD_VALID), .O_PP_ENABLE(O_PP_ENABLE),
    .O_PROTECTED(O_PROTECTED), .O_GPNV(O_GPNV), .O_BROWNOUT_EN(O_BROWNOUT_EN),
    .O_BROWNOUT_RST_EN(O_BROWNOUT_RST_EN), .O_CALIB(O_CALIB), .O_LOW_MAP(O_LOW_MAP),
    .O_ARRAY_STANDBY(O_ARRAY_STANDBY));
`default_nettype wire

//--- bench/tb.sv
// Purpose : Self-checking bench for fnc_ctrl against a small bench model
// Assumes : Inputs driven by non-blocking assignment at rising edges
// Notes   : Wipe hold scaled through the far side model parameter
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fnc_pkg::*;
    logic I_CLK = 1'b0, rst = 1'b1, sw_v = 1'b0, remap = 1'b0, buf_we = 1'b0, rd_req = 1'b0;
    fnc_req_t sw_req = '0;
    logic [3:0] ws = 4'h0;
    logic [7:0] opc = 8'h00;
    logic [1:0] irq_en = 2'h0, map;
    logic [5:0] buf_addr = 6'h00;
    logic [31:0] buf_wd = 32'h0, rd_d, wlast;
    logic [17:0] rd_addr = 18'h0;
    logic wipe, tst, pa0, pa1, pp_v, irq, rd_v, pp_en, pp_ref, prot, bo_en, bo_rst, stby;
    fnc_req_t pp_req;
    fnc_stat_t st;
    logic [2:0] gpnv;
    logic [7:0] calib;
    logic [31:0] words [64];
    int err_total = 0, comparisons = 0, gpnv_m = 0, prot_m = 0, remap_m = 0, op, n;
    always #2 I_CLK = ~I_CLK; // 250 MHz
    // -----------------------------------------------------------
    // Design and far side
    // -----------------------------------------------------------
    fnc_ctrl i_dut (.I_CLK(I_CLK), .I_RESET(rst), .I_SW_REQ(sw_req), .I_SW_REQ_VALID(sw_v),
        .I_WAIT_STATES(ws), .I_OP_CYCLES(opc), .I_IRQ_ENABLE(irq_en), .I_REMAP(remap),
        .I_BUF_WE(buf_we), .I_BUF_ADDR(buf_addr), .I_BUF_WDATA(buf_wd), .I_RD_REQ(rd_req),
        .I_RD_ADDR(rd_addr), .I_WIPE_PIN(wipe), .I_TEST_MODE_PIN(tst),
        .I_PORT_A_LINE_ZERO(pa0), .I_PORT_A_LINE_ONE(pa1), .I_PP_REQ(pp_req),
        .I_PP_REQ_VALID(pp_v), .O_STATUS(st), .O_IRQ(irq), .O_RD_VALID(rd_v),
        .O_RD_DATA(rd_d), .O_PP_ENABLE(pp_en), .O_PP_REFUSED(pp_ref), .O_PROTECTED(prot),
        .O_GPNV(gpnv), .O_BROWNOUT_EN(bo_en), .O_BROWNOUT_RST_EN(bo_rst), .O_CALIB(calib),
        .O_LOW_MAP(map), .O_LOW_WIN_LAST(wlast), .O_ARRAY_STANDBY(stby));
    fnc_prog_model #(.WIPE_MS(220), .CYC_PER_MS(4)) i_prog (.i_clk(I_CLK),
        .o_wipe_pin(wipe), .o_test_mode_pin(tst), .o_line_zero(pa0), .o_line_one(pa1),
        .o_pp_req(pp_req), .o_pp_req_valid(pp_v));
    // -----------------------------------------------------------
    // Compare and report tasks
    // -----------------------------------------------------------
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit
    task automatic tally_and_finish();
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // NV state and map against the model
    task automatic chk_nv();
        cmp_word({29'h0, gpnv}, gpnv_m);
        cmp_bit(bo_en, gpnv_m[0]);
        cmp_bit(bo_rst, gpnv_m[1]);
        cmp_bit(prot, prot_m[0]);
        cmp_word({30'h0, map}, remap_m ? MAP_SRAM : (gpnv_m[2] ? MAP_FLASH : MAP_ROM));
    endtask : chk_nv
    // Wait until idle, counting edges
    task automatic wait_idle();
        for (int i = 0; i < 70000 && st.busy !== 1'b0; i++) begin
            @(posedge I_CLK);
            #1;
            n++;
        end
    endtask : wait_idle
    // Software command; lat is edges from accept to done, 0 skips the check
    task automatic sw_cmd(input fnc_cmd_t c, input int p, input int lat);
        wait_idle();
        @(posedge I_CLK);
        sw_req <= '{cmd: c, page: p[PAGE_AW-1:0]};
        sw_v <= 1'b1;
        @(posedge I_CLK);
        sw_v <= 1'b0;
        #1;
        n = 1;
        wait_idle();
        if (lat > 0) cmp_word(n, lat);
    endtask : sw_cmd
    // Fetch one word and check data and latency
    task automatic rd_word(input int p, input int w, input int lat);
        @(posedge I_CLK);
        rd_req <= 1'b1;
        rd_addr <= 18'(p * PAGE_BYTES + w * 4);
        @(posedge I_CLK);
        rd_req <= 1'b0;
        #1;
        for (n = 1; n < 40 && rd_v !== 1'b1; n++) @(posedge I_CLK) #1;
        cmp_word(rd_d, words[w]);
        cmp_word(n, lat);
    endtask : rd_word
    // -----------------------------------------------------------
    // Watchdog
    // -----------------------------------------------------------
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        n = $urandom(32'h33422585);
        op = $urandom % 4;
        opc = 8'(op);
        ws = 4'($urandom % 16);
        repeat (8) @(posedge I_CLK);
        rst <= 1'b0;
        #1;
        cmp_word(calib, CALIB_FACTORY);
        cmp_word(wlast, LOW_WIN_LAST);
        cmp_bit(stby, 1'b1);
        chk_nv();
        for (int b = 0; b < GPNV_COUNT; b++) begin
            sw_cmd(CMD_SET_GPNV, b, op + 2);
            gpnv_m |= 1 << b;
            chk_nv();
        end
        sw_cmd(CMD_CLR_GPNV, 1, op + 2);
        gpnv_m &= 5;
        chk_nv();
        @(posedge I_CLK) irq_en <= 2'h1;
        @(posedge I_CLK) #1 cmp_bit(irq, 1'b1);
        irq_en <= 2'h2;
        @(posedge I_CLK) #1 cmp_bit(irq, 1'b0);
        sw_req <= '{cmd: CMD_PAGE_ERASE, page: 10'd7};
        sw_v <= 1'b1;
        @(posedge I_CLK) sw_req <= '{cmd: CMD_SET_GPNV, page: 10'd1};
        @(posedge I_CLK) sw_v <= 1'b0;
        #1 cmp_bit(st.err_busy, 1'b1);
        cmp_bit(stby, 1'b0);
        wait_idle();
        chk_nv();
        for (int w = 0; w < PAGE_WORDS; w++) begin
            words[w] = $urandom;
            @(posedge I_CLK) buf_we <= 1'b1;
            buf_addr <= 6'(w);
            buf_wd <= words[w];
        end
        @(posedge I_CLK) buf_we <= 1'b0;
        sw_cmd(CMD_PAGE_PROG, 7, PAGE_WORDS * (op + 1) + 1);
        rd_word(7, 2, ws + 2);
        rd_word(7, 3, 1);
        rd_word(7, 63, ws + 2);
        sw_cmd(CMD_LOCK, 9, op + 2);
        sw_cmd(CMD_PAGE_PROG, 9, 0);
        cmp_bit(st.err_prot, 1'b1);
        sw_cmd(CMD_UNLOCK, 9, op + 2);
        sw_cmd(CMD_PAGE_ERASE, 9, PAGE_WORDS * (op + 1) + 1);
        cmp_bit(st.err_prot, 1'b0);
        @(posedge I_CLK) remap <= 1'b1;
        @(posedge I_CLK) remap <= 1'b0;
        remap_m = 1;
        #1 chk_nv();
        i_prog.enter(1'b1);
        #1 cmp_bit(pp_en, 1'b1);
        i_prog.send(CMD_READ, 0);
        cmp_bit(pp_ref, 1'b0);
        sw_cmd(CMD_SET_PROT, 0, op + 2);
        prot_m = 1;
        chk_nv();
        i_prog.send(CMD_PAGE_ERASE, 7);
        cmp_bit(pp_ref, 1'b1);
        i_prog.enter(1'b0);
        #1 cmp_bit(pp_en, 1'b0);
        @(posedge I_CLK) rst <= 1'b1;
        @(posedge I_CLK) rst <= 1'b0;
        remap_m = 0;
        #1 chk_nv();
        i_prog.wipe();
        gpnv_m &= 4;
        #1 chk_nv();
        cmp_word(calib, CALIB_FACTORY);
        @(posedge I_CLK) opc <= 8'h00;
        op = 0;
        sw_cmd(CMD_FULL_ERASE, 0, 65536 + 1);
        prot_m = 0;
        chk_nv();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
